/* qrpo_pkg.sv */
`default_nettype none
package qrpo_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0]  QRPO_ADDR_CTRL   = 4'h0;
	localparam logic [3:0]  QRPO_ADDR_STATUS = 4'h4;
	localparam logic [3:0]  QRPO_ADDR_MASK   = 4'h8;
	localparam logic [3:0]  QRPO_ADDR_STATE  = 4'hc;

	// CTRL fields
	localparam int          QRPO_CTRL_RATE   = 0;
	localparam int          QRPO_CTRL_ST_LO  = 1;
	localparam int          QRPO_CTRL_ST_HI  = 2;
	localparam int          QRPO_CTRL_ROE1   = 3;
	localparam int          QRPO_CTRL_ROE2   = 4;
	localparam int          QRPO_CTRL_ULC    = 5;
	localparam logic [7:0]  QRPO_CTRL_RESET  = 8'h38;

	// STATUS / MASK fields
	localparam int          QRPO_EV_FAULT    = 0;
	localparam int          QRPO_EV_TRG_LOST = 1;
	localparam int          QRPO_EV_ST_FLAG  = 2;
	localparam int          QRPO_EV_W        = 3;
	localparam logic [2:0]  QRPO_EV_RESET    = 3'h0;

	// STATE fields
	localparam int          QRPO_STATE_LFN   = 0;
	localparam int          QRPO_STATE_TRG   = 1;
	localparam int          QRPO_STATE_PD    = 2;
	localparam int          QRPO_STATE_CODE  = 4;

	// ------------------------------------------------------------
	// Data path constants
	// ------------------------------------------------------------
	localparam int          QRPO_CHAR_W      = 10;
	localparam logic [1:0]  QRPO_ST_ACTIVE   = 2'h2;
	localparam logic [9:0]  QRPO_CHAR_RESET  = 10'h000;
	localparam logic [3:0]  QRPO_HALF_CYC    = 4'h2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          QRPO_CLK_MHZ     = 50;
	localparam int          QRPO_TRG_ABS_NS  = 640;
	localparam int          QRPO_TRG_ABS_CYC = (QRPO_TRG_ABS_NS * QRPO_CLK_MHZ) / 1000;
	localparam logic [7:0]  QRPO_TRG_ABS_MAX = 8'(QRPO_TRG_ABS_CYC);
endpackage : qrpo_pkg
`default_nettype wire

/* qrpo_trg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface qrpo_trg_if;
	logic trg_tick;
	logic trg_present;
	logic trg_lost_pulse;
	modport mon (output trg_tick, output trg_present, output trg_lost_pulse);
	modport use_side (input trg_tick, input trg_present, input trg_lost_pulse);
endinterface : qrpo_trg_if
`default_nettype wire

/* qrpo_trg_mon.sv */
`timescale 1ns/1ps
`default_nettype none
module qrpo_trg_mon
	import qrpo_pkg::*;
(
	input  wire logic   core_clk,
	input  wire logic   rst,
	input  wire logic   cdr_training_clk,
	qrpo_trg_if.mon     trg
);
	// ------------------------------------------------------------
	// Sync and edge find
	// ------------------------------------------------------------
	logic       meta_q;
	logic       sync_q;
	logic       last_q;
	logic [7:0] gap_q;
	logic [7:0] gap_d;
	logic       present_q;
	logic       present_d;
	logic       tick_q;
	logic       lost_q;
	wire        edge_seen = sync_q & ~last_q;

	// Absence is judged by the gap since the last rising edge
	assign gap_d     = edge_seen ? 8'h00 : (gap_q == QRPO_TRG_ABS_MAX ? gap_q : gap_q + 8'h01);
	assign present_d = edge_seen | (gap_d != QRPO_TRG_ABS_MAX);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_q    <= 1'b0;
			sync_q    <= 1'b0;
			last_q    <= 1'b0;
			gap_q     <= QRPO_TRG_ABS_MAX;
			present_q <= 1'b0;
			tick_q    <= 1'b0;
			lost_q    <= 1'b0;
		end else begin
			meta_q    <= cdr_training_clk;
			sync_q    <= meta_q;
			last_q    <= sync_q;
			gap_q     <= gap_d;
			present_q <= present_d;
			tick_q    <= edge_seen; // RL9
			lost_q    <= present_q & ~present_d;
		end
	end

	assign trg.trg_tick       = tick_q;
	assign trg.trg_present    = present_q;
	assign trg.trg_lost_pulse = lost_q;
endmodule : qrpo_trg_mon
`default_nettype wire

/* qrpo_port.sv */
// Functional notes
// RL1: Full-rate: data updates on rising true clock, falling complement.
// RL2: Half-rate: data updates on every edge of the clock pair.
// RL3: Interface clock toggles continuously at rate chosen by rate select.
// RL4: Self-test active: status on low two data bits and status pin.
// RL5: Status pin meaningful only when self-test control equals 10.
// RL6: Both reclock enables clear: power down reclock output, flag high.
// RL7: Reclock clock equals interface rate at select 0, twice at 1.
// RL8: Host assumes no phase relation between reclock and interface clocks.
// RL9: Frequency reference for the loop is the training clock.
// RL10: Host treats recovered clock as unrelated to training clock.
// RL11: Reset returns all state, counters and config to initial values.
// RL12: Reset must be held for the minimum pulse width.
// RL13: Reset leaves the test access port controller alone.
// RL14: Local-clock select low: loop locks to training clock, fault low.
// RL15: Link fault asserts low on any of six fault conditions.
// RL16: Self-test status exposed as opaque three-bit code per update.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module qrpo_port
	import qrpo_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [9:0]  rec_char,
	input  wire logic        rec_char_stb,
	input  wire logic [2:0]  selftest_code,
	input  wire logic        cdr_training_clk,
	input  wire logic        rate_oor,
	input  wire logic        low_amp,
	input  wire logic        low_td,
	input  wire logic        chan_dis,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic      [9:0]  rx_char_out,
	output logic             rx_iface_clk_p,
	output logic             rx_iface_clk_n,
	output logic             selftest_stat_out,
	output logic             reclk_out_clk,
	output logic             reclk_pwrdn_flag,
	output logic             link_fault_n,
	output logic             loop_ref_trg,
	output logic             loop_freq_tick,
	output logic             irq
);
	// ------------------------------------------------------------
	// Training clock monitor
	// ------------------------------------------------------------
	qrpo_trg_if trg_bus ();

	qrpo_trg_mon u_trg_mon (
		.core_clk         (core_clk),
		.rst              (rst),
		.cdr_training_clk (cdr_training_clk),
		.trg              (trg_bus.mon)
	);

	// ------------------------------------------------------------
	// Fault input synchronisers
	// ------------------------------------------------------------
	logic [3:0] flt_meta_q;
	logic [3:0] flt_sync_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flt_meta_q <= 4'h0;
			flt_sync_q <= 4'h0;
		end else begin
			flt_meta_q <= {chan_dis, low_td, low_amp, rate_oor};
			flt_sync_q <= flt_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	logic [7:0]          ctrl_q;
	logic [QRPO_EV_W-1:0] status_q;
	logic [QRPO_EV_W-1:0] status_d;
	logic [QRPO_EV_W-1:0] mask_q;
	logic [QRPO_EV_W-1:0] ev_set;
	logic [7:0]          rdata_d;
	logic [7:0]          state_word;

	wire wr_ctrl   = reg_wr && (reg_addr == QRPO_ADDR_CTRL);
	wire wr_status = reg_wr && (reg_addr == QRPO_ADDR_STATUS);
	wire wr_mask   = reg_wr && (reg_addr == QRPO_ADDR_MASK);

	wire       rate_half = ctrl_q[QRPO_CTRL_RATE];
	wire [1:0] st_ctl    = ctrl_q[QRPO_CTRL_ST_HI:QRPO_CTRL_ST_LO];
	wire       ulc       = ctrl_q[QRPO_CTRL_ULC];
	wire       st_active = (st_ctl == QRPO_ST_ACTIVE);
	// Power-down follows the write itself, not any character clock
	wire       pd_next   = ~(reg_wdata[QRPO_CTRL_ROE1] | reg_wdata[QRPO_CTRL_ROE2]);

	function automatic logic [7:0] ev_word(input logic [QRPO_EV_W-1:0] v);
		ev_word = {{(8 - QRPO_EV_W){1'b0}}, v};
	endfunction : ev_word

	// Set wins over a write-one clear in the same cycle
	assign status_d = (status_q & ~(wr_status ? reg_wdata[QRPO_EV_W-1:0] : {QRPO_EV_W{1'b0}})) | ev_set;

	assign state_word = {1'b0, selftest_code, 1'b0, reclk_pwrdn_flag, trg_bus.trg_present, link_fault_n};

	always_comb begin
		rdata_d = 8'h00;
		if (reg_addr == QRPO_ADDR_CTRL) begin
			rdata_d = ctrl_q;
		end else if (reg_addr == QRPO_ADDR_STATUS) begin
			rdata_d = ev_word(status_q);
		end else if (reg_addr == QRPO_ADDR_MASK) begin
			rdata_d = ev_word(mask_q);
		end else if (reg_addr == QRPO_ADDR_STATE) begin
			rdata_d = state_word;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_q           <= QRPO_CTRL_RESET; // RL11 RL13
			mask_q           <= QRPO_EV_RESET;
			status_q         <= QRPO_EV_RESET;
			reg_rdata        <= 8'h00;
			reclk_pwrdn_flag <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q           <= reg_wdata;
				reclk_pwrdn_flag <= pd_next; // RL6
			end
			if (wr_mask) begin
				mask_q <= reg_wdata[QRPO_EV_W-1:0];
			end
			status_q  <= status_d;
			reg_rdata <= reg_rd ? rdata_d : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Link fault and loop reference
	// ------------------------------------------------------------
	logic lfn_d;

	// Any one condition pulls the indicator low
	assign lfn_d = ~(|flt_sync_q | ~ulc | ~trg_bus.trg_present); // RL15

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			link_fault_n   <= 1'b0;
			loop_ref_trg   <= 1'b1;
			loop_freq_tick <= 1'b0;
		end else begin
			link_fault_n   <= lfn_d; // RL14
			loop_ref_trg   <= ~ulc; // RL14
			loop_freq_tick <= trg_bus.trg_tick; // RL9
		end
	end

	// ------------------------------------------------------------
	// Parallel output and interface clock
	// ------------------------------------------------------------
	logic [9:0] out_val;
	logic [3:0] half_q;
	logic       clk_q;

	// Low bits carry the opaque code while self-test runs
	assign out_val = st_active ? {8'h00, selftest_code[1:0]} : rec_char; // RL4 RL16

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_char_out       <= QRPO_CHAR_RESET;
			selftest_stat_out <= 1'b0;
			clk_q             <= 1'b0;
			half_q            <= 4'h0;
		end else if (rec_char_stb) begin
			rx_char_out       <= out_val;
			selftest_stat_out <= st_active & selftest_code[2]; // RL5
			half_q            <= QRPO_HALF_CYC;
			if (rate_half) begin
				clk_q <= ~clk_q; // RL2 RL3
			end else begin
				clk_q <= 1'b1; // RL1 RL3
			end
		end else if (half_q != 4'h0) begin
			half_q <= half_q - 4'h1;
			if (!rate_half && half_q == 4'h1) begin
				clk_q <= 1'b0;
			end
		end
	end

	assign rx_iface_clk_p = clk_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_iface_clk_n <= 1'b1;
		end else begin
			rx_iface_clk_n <= ~(rec_char_stb ? (rate_half ? ~clk_q : 1'b1)
				: ((!rate_half && half_q == 4'h1) ? 1'b0 : clk_q)); // RL1
		end
	end

	// ------------------------------------------------------------
	// Reclock output clock
	// ------------------------------------------------------------
	// One pulse per character at either rate unless powered down; interface rate halves instead
	logic       stb_dly_q;
	logic [3:0] rc_half_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stb_dly_q     <= 1'b0;
			rc_half_q     <= 4'h0;
			reclk_out_clk <= 1'b0;
		end else begin
			stb_dly_q <= rec_char_stb;
			if (reclk_pwrdn_flag) begin
				reclk_out_clk <= 1'b0; // RL6
				rc_half_q     <= 4'h0;
			end else if (stb_dly_q) begin
				reclk_out_clk <= 1'b1; // RL7
				rc_half_q     <= QRPO_HALF_CYC;
			end else if (rc_half_q != 4'h0) begin
				rc_half_q <= rc_half_q - 4'h1;
				if (rc_half_q == 4'h1) begin
					reclk_out_clk <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Events and interrupt
	// ------------------------------------------------------------
	logic lfn_last_q;

	always_comb begin
		ev_set                   = {QRPO_EV_W{1'b0}};
		ev_set[QRPO_EV_FAULT]    = lfn_last_q & ~link_fault_n;
		ev_set[QRPO_EV_TRG_LOST] = trg_bus.trg_lost_pulse;
		ev_set[QRPO_EV_ST_FLAG]  = rec_char_stb & st_active & selftest_code[2];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lfn_last_q <= 1'b0;
			irq        <= 1'b0;
		end else begin
			lfn_last_q <= link_fault_n;
			irq        <= |(status_d & mask_q);
		end
	end
endmodule : qrpo_port
`default_nettype wire

/* qrpo_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module qrpo_port_asserts
	import qrpo_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [9:0] rec_char,
	input wire logic       rec_char_stb,
	input wire logic [2:0] selftest_code,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic [9:0] rx_char_out,
	input wire logic       rx_iface_clk_p,
	input wire logic       rx_iface_clk_n,
	input wire logic       selftest_stat_out,
	input wire logic       reclk_out_clk,
	input wire logic       reclk_pwrdn_flag,
	input wire logic       link_fault_n,
	input wire logic       loop_ref_trg,
	input wire logic       loop_freq_tick
);
	// ------------------------------------------------
	// Checks
	// ------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_PAIR: assert property (rx_iface_clk_p != rx_iface_clk_n)
		else $error("clock pair not complementary");
	AST_DATA_EDGE: assert property ($changed(rx_char_out) |-> $changed(rx_iface_clk_p))
		else $error("data moved without clock edge");
	AST_CHAR: assert property (rec_char_stb |=>
		rx_char_out == $past(rec_char) || rx_char_out == {8'h00, $past(selftest_code[1:0])})
		else $error("wrong character out");
	AST_STAT: assert property ($rose(selftest_stat_out) |-> $past(rec_char_stb) || $past(reg_wr))
		else $error("status rose outside an update");
	AST_PD: assert property (reg_wr && reg_addr == QRPO_ADDR_CTRL |=>
		reclk_pwrdn_flag == ~|$past(reg_wdata[4:3]))
		else $error("power down flag wrong");
	AST_PD_CLK: assert property (reclk_pwrdn_flag [*2] |-> !reclk_out_clk)
		else $error("reclock clock runs while powered down");
	AST_RECLK: assert property ($rose(reclk_out_clk) |=> reclk_out_clk ##1 !reclk_out_clk)
		else $error("reclock pulse width wrong");
	AST_TICK: assert property (loop_freq_tick |=> !loop_freq_tick [*5])
		else $error("reference tick too frequent");
	AST_ULC: assert property (loop_ref_trg [*4] |-> !link_fault_n)
		else $error("fault not shown on local lock");
endmodule : qrpo_port_asserts
`default_nettype wire

/* qrpo_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module qrpo_host_model (
	input  wire logic       half,
	input  wire logic       clk_p,
	input  wire logic [9:0] data,
	output logic      [9:0] cap
);
	// Captures just after each active edge, once the word has settled
	always @(posedge clk_p) #1 cap = data;
	always @(negedge clk_p) if (half) #1 cap = data;
	// Reclock clock deliberately unused: no phase relation assumed
endmodule : qrpo_host_model
`default_nettype wire

/* qrpo_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; \
	$display("mismatch %s exp %0h got %0h", n, e, s); end end
module testbench;
	import qrpo_pkg::*;
	logic core_clk = 0, rst = 1, stb = 0, trg = 0, run = 0, wr = 0, rd = 0;
	logic [9:0] ch = 0;
	logic [2:0] code = 0;
	logic [7:0] modes [4] = '{8'h38, 8'h3b, 8'h3c, 8'h3f};
	logic [3:0] fl = 0, addr = 0;
	logic [7:0] wd = 0, rdata;
	logic [9:0] dout, cap;
	logic cp, st, rck, pd, lfn, lref, tick, irq, hf = 0;
	int nrec = 0, nif = 0, ntick = 0, ntrg = 0, mismatches = 0, comparisons = 0;
	always #10 core_clk = ~core_clk;
	// Unrelated phase to the core clock
	initial #3 forever #80 if (run) trg = ~trg;
	always @(posedge rck) nrec++;
	always @(posedge cp) nif++;
	always @(posedge tick) ntick++;
	always @(posedge trg) ntrg++;
	qrpo_port dut (.core_clk(core_clk), .rst(rst), .rec_char(ch), .rec_char_stb(stb),
		.selftest_code(code), .cdr_training_clk(trg), .rate_oor(fl[0]), .low_amp(fl[1]),
		.low_td(fl[2]), .chan_dis(fl[3]), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdata), .rx_char_out(dout), .rx_iface_clk_p(cp), .rx_iface_clk_n(),
		.selftest_stat_out(st), .reclk_out_clk(rck), .reclk_pwrdn_flag(pd), .link_fault_n(lfn),
		.loop_ref_trg(lref), .loop_freq_tick(tick), .irq(irq));
	qrpo_host_model host (.half(hf), .clk_p(cp), .data(dout), .cap(cap));
	function automatic logic [9:0] exp_char(logic [9:0] c, logic [2:0] k, logic s);
		return s ? {8'h00, k[1:0]} : c;
	endfunction : exp_char
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	task automatic wr_reg(logic [3:0] a, logic [7:0] d);
		@(posedge core_clk);
		addr <= a; wd <= d; wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		#2;
	endtask : wr_reg
	task automatic rd_chk(logic [3:0] a, logic [7:0] e, string n);
		@(posedge core_clk);
		addr <= a; rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#2 `CHK(n, e, rdata)
	endtask : rd_chk
	task automatic chr(logic [9:0] c, logic [2:0] k);
		@(posedge core_clk);
		ch <= c; code <= k; stb <= 1'b1;
		@(posedge core_clk);
		stb <= 1'b0;
		#2;
	endtask : chr
	task automatic wait_lfn(logic v, int n);
		for (int i = 0; i < n && lfn !== v; i++) begin
			@(posedge core_clk);
			#2;
		end
		`CHK("link_fault_n", v, lfn)
		if (lfn !== v) summarize();
	endtask : wait_lfn
	// Each mode: random words, clock edges and reclock pulses counted
	task automatic run_mode(logic [7:0] ctl);
		int r0, i0;
		logic s, p;
		logic [9:0] c;
		logic [2:0] k;
		s = (ctl[2:1] == QRPO_ST_ACTIVE);
		wr_reg(QRPO_ADDR_CTRL, ctl);
		hf = ctl[0]; r0 = nrec; i0 = nif;
		repeat (8) begin
			c = 10'($urandom); k = 3'($urandom); p = cp;
			chr(c, k);
			`CHK("data", exp_char(c, k, s), dout)
			`CHK("host", exp_char(c, k, s), cap)
			`CHK("clk_p", hf ? ~p : 1'b1, cp)
			`CHK("stat", s & k[2], st)
			repeat (3) @(posedge core_clk);
			#2 if (!hf) `CHK("clk_p low", 1'b0, cp)
		end
		`CHK("reclk", 8, nrec - r0)
		`CHK("iface", hf ? 4 : 8, nif - i0)
	endtask : run_mode
	initial begin
		void'($urandom(31522));
		// Held well past the minimum pulse; no test port to reset here
		repeat (12) @(posedge core_clk);
		`CHK("pwrdn", 1'b0, pd)
		rst <= 1'b0;
		rd_chk(QRPO_ADDR_CTRL, QRPO_CTRL_RESET, "ctrl");
		rd_chk(4'h2, 8'h00, "unmapped");
		`CHK("link_fault_n", 1'b0, lfn)
		run = 1;
		wait_lfn(1'b1, 60);
		foreach (modes[j]) run_mode(modes[j]);
		`CHK("ticks", 1'b1, (ntrg - ntick) inside {0, 1})
		for (int j = 0; j < 4; j++) begin
			int r0;
			r0 = nrec;
			wr_reg(QRPO_ADDR_CTRL, 8'h20 | 8'(j << 3));
			`CHK("pwrdn", j == 0, pd)
			chr(10'h155, 3'h0);
			repeat (4) @(posedge core_clk);
			`CHK("reclk gated", j != 0, nrec - r0)
		end
		wr_reg(QRPO_ADDR_CTRL, 8'h18);
		wait_lfn(1'b0, 10);
		`CHK("loop_ref", 1'b1, lref)
		wr_reg(QRPO_ADDR_CTRL, 8'h38);
		wait_lfn(1'b1, 10);
		for (int j = 0; j < 4; j++) begin
			@(posedge core_clk);
			fl[j] <= 1'b1;
			wait_lfn(1'b0, 10);
			fl[j] <= 1'b0;
			wait_lfn(1'b1, 10);
		end
		wr_reg(QRPO_ADDR_STATUS, 8'h07);
		run = 0;
		wait_lfn(1'b0, 60);
		wr_reg(QRPO_ADDR_STATE, 8'hff);
		`CHK("irq masked", 1'b0, irq)
		rd_chk(QRPO_ADDR_STATUS, 8'h03, "status");
		wr_reg(QRPO_ADDR_MASK, 8'h02);
		@(posedge core_clk);
		#2 `CHK("irq", 1'b1, irq)
		wr_reg(QRPO_ADDR_STATUS, 8'h02);
		@(posedge core_clk);
		#2 `CHK("irq clear", 1'b0, irq)
		rd_chk(QRPO_ADDR_STATUS, 8'h01, "status w1c");
		wr_reg(QRPO_ADDR_CTRL, 8'h01);
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rd_chk(QRPO_ADDR_CTRL, QRPO_CTRL_RESET, "ctrl again");
		rd_chk(QRPO_ADDR_MASK, 8'h00, "mask again");
		summarize();
	end
endmodule : testbench
bind qrpo_port qrpo_port_asserts u_ast (.core_clk(core_clk), .rst(rst), .rec_char(rec_char),
	.rec_char_stb(rec_char_stb), .selftest_code(selftest_code), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .rx_char_out(rx_char_out), .rx_iface_clk_p(rx_iface_clk_p),
	.rx_iface_clk_n(rx_iface_clk_n), .selftest_stat_out(selftest_stat_out), .reclk_out_clk(reclk_out_clk),
	.reclk_pwrdn_flag(reclk_pwrdn_flag), .link_fault_n(link_fault_n), .loop_ref_trg(loop_ref_trg),
	.loop_freq_tick(loop_freq_tick));
`default_nettype wire
